// file: src/hls_pkg.sv
/*
 Package of the homing sequencer: register map, field positions, reset values,
 error codes, timing constants and shared types.
 Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
// How it works
// (R1) Stopper start ignores the zero pass flag
// (R2) Stopper homing never uses retry
// (R3) Stopper start with complete set: error 115
// (R4) Limit method: home direction, fast, no dog
// (R5) Home limit ON-OFF: stop, creep back, zero
// (R6) No external inputs assigned: refuse, error 142
// (R7) Opposite limit ON-OFF: stop, major 1101/1102
// (R8) Limit method never uses retry
// (R9) Home limit already OFF: creep reverse at start
// (R10) No zero pass before limit stop: error 120
// (R11) Retry enable bit, reset value zero
// (R12) Dwell 0 to 5000 ms, stopped meanwhile
// (R13) Work toward home same way: normal homing
// (R14) Work toward home opposite: stop on dog OFF
// (R15) One dwell value for both retry stops
// (R16) Retry only for dog, count, cradle methods
// (R17) Retry only while servo is ON
// (R18) Retry limit hit reverses without major error
// (R19) Complete only on success; errors latched
package hls_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_DWELL  = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_ERR    = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_ST = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MK = 8'h14;
   // Control fields
   localparam int CTRL_START   = 0;
   localparam int CTRL_METH_LO = 1;
   localparam int CTRL_DIR     = 4;
   localparam int CTRL_RETRY   = 5;
   localparam int CTRL_EXT     = 6;
   localparam int CTRL_COND    = 7;
   localparam int CTRL_CLR_CMP = 8;
   // Reset values and dwell limit
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [12:0] DWELL_RST = 13'h0000;
   localparam logic [12:0] DWELL_MAX = 13'd5000;
   // Interrupt bit positions
   localparam int IRQ_DONE  = 0;
   localparam int IRQ_MINOR = 1;
   localparam int IRQ_MAJOR = 2;
   // ----------------------------------------
   // Error codes
   // ----------------------------------------
   localparam logic [15:0] ERR_CMP_ON   = 16'd115;
   localparam logic [15:0] ERR_NO_ZERO  = 16'd120;
   localparam logic [15:0] ERR_NO_EXT   = 16'd142;
   localparam logic [15:0] ERR_LIM_FWD  = 16'd1001;
   localparam logic [15:0] ERR_LIM_REV  = 16'd1002;
   localparam logic [15:0] ERR_HLIM_FWD = 16'd1101;
   localparam logic [15:0] ERR_HLIM_REV = 16'd1102;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_HZ       = 50_000_000;
   localparam int DWELL_UNIT_US = 1000;
   localparam int CYC_PER_MS   = CLK_HZ / 1_000_000 * DWELL_UNIT_US;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      METH_DOG, METH_COUNT, METH_DATASET, METH_CRADLE, METH_STOPPER, METH_LIMIT
   } hls_meth_t;
   typedef struct packed {
      logic move;    // Travel command; low means decelerate and stop
      logic rev;     // 1 = toward lower limit
      logic creep;   // 1 = creep speed, 0 = homing speed
   } hls_motion_t;
endpackage

// file: src/hls_sequencer.sv
/*
 Per-axis homing sequencer with AXI4-Lite register slave and interrupt.
 Assumes synchronous axis inputs, limit switches high while ON, a zero
 pulse input from the encoder, and a stopped indication from the amplifier.
*/
`timescale 1ns/1ps
module hls_sequencer
   import hls_pkg::*;
#(
   parameter int DWELL_DIV = CYC_PER_MS   // Cycles per dwell millisecond
)
(
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_N_I,
   input  wire logic [7:0]  AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [7:0]  ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   input  wire logic        LIMIT_UP_I,     // Upper limit switch, high = ON
   input  wire logic        LIMIT_LO_I,     // Lower limit switch, high = ON
   input  wire logic        DOG_I,          // Proximity dog, high = ON
   input  wire logic        ZERO_PULSE_I,   // One pulse per zero point
   input  wire logic        ZERO_PASS_FLAG_I, // zero_pass_flag
   input  wire logic        TORQUE_LIM_I,   // Torque limiting reached
   input  wire logic        STOPPED_I,      // Axis at standstill
   input  wire logic        SERVO_ON_I,
   output hls_motion_t      MOTION_O,
   output logic             HOME_LATCH_O,   // Take current position as home
   output logic             IRQ_O
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum {
      S_IDLE, S_FAST, S_LS_STOP, S_LS_CREEP, S_ERR_STOP, S_STOPPER,
      S_DOG_SEEK, S_DOG_CREEP, S_DWELL_REV, S_RETRY_REV, S_DWELL_FWD
   } hls_state_t;
   hls_state_t  state_q, state_d;        // Sequencer state
   logic [7:0]  ctrl_q;                  // Method, direction, options
   logic [12:0] dwell_q;                 // Retry dwell in ms
   logic [2:0]  irq_st_q, irq_mk_q;      // Sticky events and mask
   logic        complete_q;              // Homing complete flag
   logic        major_q, minor_q;        // Error class of last error
   logic [15:0] err_code_q;              // Last error code
   logic        zp_seen_q, zp_seen_d;    // Zero point passed since start
   logic        dog_seen_q, dog_seen_d;  // Dog seen ON during retry reverse
   logic        retry_q, retry_d;        // Retry armed for this run
   logic        up_q, lo_q;              // Previous limit levels
   logic [15:0] div_q;                   // Millisecond divider
   logic [12:0] ms_q;                    // Dwell milliseconds elapsed
   logic        ms_tick;                 // One-cycle ms enable
   logic        ev_done, ev_minor, ev_major;
   logic [15:0] ev_code;
   hls_motion_t mot_d;
   logic        latch_d;
   logic        aw_q, w_q, wr_go, start_w;
   logic [7:0]  awaddr_q, rd_addr;
   logic [31:0] wdata_q;
   logic [7:0]  ctrl_v;                  // Control as a start in this write sees it
   hls_meth_t   meth;
   logic        hdir, home_lim, opp_lim, home_fall, opp_fall, dwell_done, dog_meth;

   // A start written together with its method must not run on the old setup
   assign ctrl_v   = (start_w && state_q == S_IDLE) ? {wdata_q[7:1], 1'b0} : ctrl_q;
   assign meth     = hls_meth_t'(ctrl_v[CTRL_METH_LO +: 3]);
   assign hdir     = ctrl_v[CTRL_DIR];
   assign home_lim = hdir ? LIMIT_LO_I : LIMIT_UP_I;
   assign opp_lim  = hdir ? LIMIT_UP_I : LIMIT_LO_I;
   // ON to OFF edges of each limit relative to homing direction
   assign home_fall = (hdir ? lo_q : up_q) & ~home_lim;
   assign opp_fall  = (hdir ? up_q : lo_q) & ~opp_lim;
   assign dwell_done = STOPPED_I && (ms_q >= dwell_q);
   // Retry is only meaningful for dog based methods
   assign dog_meth = (meth == METH_DOG) || (meth == METH_COUNT) || (meth == METH_CRADLE); // (R16)

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   // Address and data are caught independently; the write fires once both
   // are held and no response is pending, so one write is in flight.
   assign AWREADY_O = !aw_q && !BVALID_O;
   assign WREADY_O  = !w_q && !BVALID_O;
   assign ARREADY_O = !RVALID_O;
   assign wr_go     = aw_q && w_q && !BVALID_O;
   assign start_w   = wr_go && (awaddr_q == ADDR_CTRL) && wdata_q[CTRL_START] && WSTRB_I[0];
   assign rd_addr   = ARADDR_I;

   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         aw_q     <= 1'b0;
         w_q      <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q  <= 32'h0000_0000;
         BVALID_O <= 1'b0;
         BRESP_O  <= 2'b00;
      end
      else
      begin
         if (AWVALID_I && AWREADY_O)
         begin
            aw_q     <= 1'b1;
            awaddr_q <= AWADDR_I;
         end
         if (WVALID_I && WREADY_O)
         begin
            w_q     <= 1'b1;
            wdata_q <= WDATA_I;
         end
         if (wr_go)
         begin
            aw_q     <= 1'b0;
            w_q      <= 1'b0;
            BVALID_O <= 1'b1;
            // Unmapped or read-only words answer SLVERR
            BRESP_O  <= (awaddr_q == ADDR_CTRL || awaddr_q == ADDR_DWELL || awaddr_q == ADDR_IRQ_ST
                         || awaddr_q == ADDR_IRQ_MK) ? 2'b00 : 2'b10;
         end
         else if (BVALID_O && BREADY_I)
            BVALID_O <= 1'b0;
      end
   end

   // Read data path, one cycle after the address is taken
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         RVALID_O <= 1'b0;
         RDATA_O  <= 32'h0000_0000;
         RRESP_O  <= 2'b00;
      end
      else if (ARVALID_I && ARREADY_O)
      begin
         RVALID_O <= 1'b1;
         RRESP_O  <= 2'b00;
         case (rd_addr)
            ADDR_CTRL:   RDATA_O <= {24'h000000, ctrl_q};
            ADDR_DWELL:  RDATA_O <= {19'h00000, dwell_q};
            ADDR_STATUS: RDATA_O <= {24'h000000, 4'(state_q), minor_q, major_q, state_q != S_IDLE, complete_q};
            ADDR_ERR:    RDATA_O <= {16'h0000, err_code_q};
            ADDR_IRQ_ST: RDATA_O <= {29'h00000000, irq_st_q};
            ADDR_IRQ_MK: RDATA_O <= {29'h00000000, irq_mk_q};
            default:
            begin
               RDATA_O <= 32'h0000_0000;
               RRESP_O <= 2'b10;
            end
         endcase
      end
      else if (RVALID_O && RREADY_I)
         RVALID_O <= 1'b0;
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   // Start and clear-complete bits are strobes and never stored
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         ctrl_q   <= CTRL_RST;                                   // (R11)
         dwell_q  <= DWELL_RST;
         irq_mk_q <= 3'h0;
      end
      else if (wr_go)
      begin
         if (awaddr_q == ADDR_CTRL && WSTRB_I[0] && state_q == S_IDLE)
            ctrl_q <= {wdata_q[7:1], 1'b0};
         // Out of range dwell saturates at the longest allowed
         if (awaddr_q == ADDR_DWELL && WSTRB_I[1:0] == 2'b11)
            dwell_q <= (wdata_q[15:0] > 16'(DWELL_MAX)) ? DWELL_MAX : wdata_q[12:0]; // (R12)
         if (awaddr_q == ADDR_IRQ_MK && WSTRB_I[0])
            irq_mk_q <= wdata_q[2:0];
      end
   end

   // ----------------------------------------
   // Dwell timer
   // ----------------------------------------
   // Counts milliseconds only while in a dwell state; one value serves both
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         div_q <= 16'h0000;
         ms_q  <= 13'h0000;
      end
      else if (state_q != S_DWELL_REV && state_q != S_DWELL_FWD)
      begin
         div_q <= 16'h0000;
         ms_q  <= 13'h0000;
      end
      else if (STOPPED_I)
      begin
         div_q <= ms_tick ? 16'h0000 : div_q + 16'h0001;
         if (ms_tick && ms_q != DWELL_MAX)
            ms_q <= ms_q + 13'h0001;                             // (R15)
      end
   end
   assign ms_tick = (div_q == 16'(DWELL_DIV - 1));

   // ----------------------------------------
   // Sequencer next state
   // ----------------------------------------
   always_comb
   begin
      state_d    = state_q;
      zp_seen_d  = zp_seen_q | ZERO_PULSE_I | ZERO_PASS_FLAG_I;
      dog_seen_d = dog_seen_q;
      retry_d    = retry_q;
      ev_done    = 1'b0;
      ev_minor   = 1'b0;
      ev_major   = 1'b0;
      ev_code    = 16'h0000;
      latch_d    = 1'b0;
      case (state_q)
         S_IDLE:
         begin
            if (start_w)
            begin
               zp_seen_d  = 1'b0;
               dog_seen_d = 1'b0;
               // Retry armed only for dog methods with servo ON
               retry_d    = ctrl_v[CTRL_RETRY] && dog_meth && SERVO_ON_I; // (R2) (R8) (R16) (R17)
               case (meth)
                  METH_STOPPER:
                     if (complete_q)
                     begin
                        ev_minor = 1'b1;                         // (R3)
                        ev_code  = ERR_CMP_ON;
                     end
                     else
                        state_d = S_STOPPER;                     // (R1)
                  METH_LIMIT:
                     if (!ctrl_v[CTRL_EXT])
                     begin
                        ev_minor = 1'b1;                         // (R6)
                        ev_code  = ERR_NO_EXT;
                     end
                     else if (!home_lim)
                        state_d = S_LS_CREEP;                    // (R9)
                     else
                        state_d = S_FAST;                        // (R4)
                  METH_DATASET:
                  begin
                     ev_done = 1'b1;
                     latch_d = 1'b1;
                  end
                  default:
                     state_d = DOG_I ? S_DOG_CREEP : S_DOG_SEEK; // (R13)
               endcase
            end
         end
         S_FAST:
            if (opp_fall)
            begin
               ev_major = 1'b1;                                  // (R7)
               ev_code  = hdir ? ERR_HLIM_REV : ERR_HLIM_FWD;
               state_d  = S_ERR_STOP;
            end
            else if (home_fall)
               state_d = S_LS_STOP;                              // (R5)
         S_LS_STOP:
            if (STOPPED_I)
            begin
               if (!zp_seen_q && !ctrl_q[CTRL_COND])
               begin
                  ev_minor = 1'b1;                               // (R10)
                  ev_code  = ERR_NO_ZERO;
                  state_d  = S_IDLE;
               end
               else
                  state_d = S_LS_CREEP;
            end
         S_LS_CREEP:
            // First zero back from the limit is the one just inside it
            if (opp_fall)
            begin
               ev_major = 1'b1;                                  // (R7)
               ev_code  = hdir ? ERR_HLIM_REV : ERR_HLIM_FWD;
               state_d  = S_ERR_STOP;
            end
            else if (ZERO_PULSE_I)
            begin
               ev_done = 1'b1;                                   // (R5)
               latch_d = 1'b1;
               state_d = S_IDLE;
            end
         S_STOPPER:
            if (TORQUE_LIM_I)
            begin
               ev_done = 1'b1;
               latch_d = 1'b1;
               state_d = S_IDLE;
            end
         S_DOG_SEEK:
            if (home_fall || opp_fall)
            begin
               if (retry_q && SERVO_ON_I)
                  state_d = S_DWELL_REV;                         // (R18)
               else
               begin
                  ev_major = 1'b1;
                  ev_code  = (home_fall ^ hdir) ? ERR_LIM_FWD : ERR_LIM_REV;
                  state_d  = S_ERR_STOP;
               end
            end
            else if (DOG_I)
               state_d = S_DOG_CREEP;
         S_DOG_CREEP:
            if (ZERO_PULSE_I)
            begin
               ev_done = 1'b1;
               latch_d = 1'b1;
               state_d = S_IDLE;
            end
         S_DWELL_REV:
            if (dwell_done)
               state_d = S_RETRY_REV;                            // (R12)
         S_RETRY_REV:
         begin
            dog_seen_d = dog_seen_q | DOG_I;
            if (!SERVO_ON_I)
               state_d = S_ERR_STOP;
            else if (dog_seen_q && !DOG_I)
               state_d = S_DWELL_FWD;                            // (R14)
         end
         S_DWELL_FWD:
            if (dwell_done)
               state_d = S_DOG_SEEK;                             // (R15)
         S_ERR_STOP:
            if (STOPPED_I)
               state_d = S_IDLE;
         default:
            state_d = S_IDLE;
      endcase
   end

   // Travel command for each state; stop states drive move low
   always_comb
   begin
      mot_d = '0;
      case (state_d)
         S_FAST:      mot_d = '{move: 1'b1, rev: hdir, creep: 1'b0};   // (R4)
         S_LS_CREEP:  mot_d = '{move: 1'b1, rev: !hdir, creep: 1'b1};  // (R5) (R9)
         S_STOPPER:   mot_d = '{move: 1'b1, rev: hdir, creep: 1'b1};
         S_DOG_SEEK:  mot_d = '{move: 1'b1, rev: hdir, creep: 1'b0};
         S_DOG_CREEP: mot_d = '{move: 1'b1, rev: hdir, creep: 1'b1};
         S_RETRY_REV: mot_d = '{move: 1'b1, rev: !hdir, creep: 1'b0};
         default:     mot_d = '{move: 1'b0, rev: hdir, creep: 1'b0};
      endcase
   end

   // ----------------------------------------
   // Sequencer registers
   // ----------------------------------------
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         state_q      <= S_IDLE;
         zp_seen_q    <= 1'b0;
         dog_seen_q   <= 1'b0;
         retry_q      <= 1'b0;
         up_q         <= 1'b0;
         lo_q         <= 1'b0;
         MOTION_O     <= '0;
         HOME_LATCH_O <= 1'b0;
      end
      else
      begin
         state_q      <= state_d;
         zp_seen_q    <= zp_seen_d;
         dog_seen_q   <= dog_seen_d;
         retry_q      <= retry_d;
         up_q         <= LIMIT_UP_I;
         lo_q         <= LIMIT_LO_I;
         MOTION_O     <= mot_d;
         HOME_LATCH_O <= latch_d;
      end
   end

   // ----------------------------------------
   // Status, error and interrupt
   // ----------------------------------------
   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge CLK_SYS_I or negedge RESET_N_I)
   begin
      if (!RESET_N_I)
      begin
         complete_q <= 1'b0;
         major_q    <= 1'b0;
         minor_q    <= 1'b0;
         err_code_q <= 16'h0000;
         irq_st_q   <= 3'h0;
      end
      else
      begin
         if (ev_done)
            complete_q <= 1'b1;                                  // (R19)
         else if ((start_w && state_q == S_IDLE && meth != METH_STOPPER)
                  || (wr_go && awaddr_q == ADDR_CTRL && wdata_q[CTRL_CLR_CMP] && WSTRB_I[1]))
            complete_q <= 1'b0;
         if (ev_minor || ev_major)
         begin
            err_code_q <= ev_code;                               // (R19)
            major_q    <= ev_major;
            minor_q    <= ev_minor;
         end
         irq_st_q <= (irq_st_q & ~((wr_go && awaddr_q == ADDR_IRQ_ST && WSTRB_I[0]) ? wdata_q[2:0] : 3'h0))
                     | {ev_major, ev_minor, ev_done};
      end
   end
   assign IRQ_O = |(irq_st_q & irq_mk_q);

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RESET_N_I);

   a_stopper_refuse: assert property (start_w && state_q == S_IDLE && meth == METH_STOPPER && complete_q // (R3)
      |=> err_code_q == ERR_CMP_ON && minor_q && state_q == S_IDLE) else $error("stopper restart not refused");
   a_stopper_no_zp: assert property (start_w && state_q == S_IDLE && meth == METH_STOPPER && !complete_q // (R1)
      |=> state_q == S_STOPPER) else $error("stopper start blocked");
   a_ext_refuse: assert property (start_w && state_q == S_IDLE && meth == METH_LIMIT && !ctrl_v[CTRL_EXT] // (R6)
      |=> err_code_q == ERR_NO_EXT && state_q == S_IDLE) else $error("missing 142");
   a_lim_off_start: assert property (start_w && state_q == S_IDLE && meth == METH_LIMIT && ctrl_v[CTRL_EXT] // (R9)
      && !home_lim |=> ##1 MOTION_O.move && MOTION_O.creep && MOTION_O.rev != hdir) else $error("no creep reverse");
   a_opp_major: assert property (state_q == S_FAST && opp_fall // (R7)
      |=> major_q && (err_code_q == ERR_HLIM_FWD || err_code_q == ERR_HLIM_REV) && !complete_q)
      else $error("opposite limit missed");
   a_no_retry_meth: assert property (state_q == S_DWELL_REV || state_q == S_RETRY_REV // (R8)
      |-> dog_meth && retry_q) else $error("retry on wrong method");
   a_retry_servo: assert property ($rose(state_q == S_DWELL_REV) |-> $past(SERVO_ON_I)) // (R17)
      else $error("retry without servo");
   a_dwell_still: assert property (state_q == S_DWELL_FWD && $past(state_q) == S_DWELL_FWD // (R12)
      |-> !MOTION_O.move) else $error("moving in dwell");
   a_zero_miss: assert property (state_q == S_LS_STOP && STOPPED_I && !zp_seen_q && !ctrl_q[CTRL_COND] // (R10)
      |=> err_code_q == ERR_NO_ZERO && !complete_q) else $error("missing 120");
   a_complete_cause: assert property ($rose(complete_q) |-> $past(ev_done) ##1 HOME_LATCH_O == 1'b0) // (R19)
      else $error("complete without success");

   c_stopper_done: cover property (state_q == S_STOPPER ##1 state_q == S_IDLE && complete_q);
   c_limit_done:   cover property (state_q == S_LS_CREEP && ZERO_PULSE_I);
   c_retry_turn:   cover property (state_q == S_RETRY_REV ##[1:200] state_q == S_DWELL_FWD);
endmodule

// file: tb/hls_axis_model.sv
/*
 Axis model: reports standstill some cycles after travel is dropped.
 Assumes the motion command of the homing sequencer.
*/
`timescale 1ns/1ps
module hls_axis_model
   import hls_pkg::*;
(
   input  wire logic        clk_i,
   input  wire hls_motion_t motion_i,
   output logic             stopped_o
);
   logic [1:0] dec_q = 2'h3; // Braking cycles left
   // Braking takes time, so standstill never follows the stop at once
   always_ff @(posedge clk_i)
   begin
      if (motion_i.move)
         dec_q <= 2'h3;
      else if (dec_q != 2'h0)
         dec_q <= dec_q - 2'h1;
   end
   assign stopped_o = !motion_i.move && dec_q == 2'h0;
endmodule

// file: tb/axis_homing_limit_retry_sequencer_test.sv
/*
 Self-checking bench of the homing sequencer.
 Assumes the axis model for standstill; switches are driven here.
*/
`timescale 1ns/1ps
module axis_homing_limit_retry_sequencer_test
   import hls_pkg::*;
;
   logic clk = 1'h0, rst_n = 1'h0, awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0;
   logic lup = 1'h1, llo = 1'h1, zp = 1'h0, tq = 1'h0, dg = 1'h0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rdt, v;
   logic awr, wr_rdy, bv, arr, rv, stp, irq;
   logic [1:0] br, rr;
   hls_motion_t mo;
   int err_total = 0, n_tests = 0;
   // ----------------------------------------
   // Design and axis
   // ----------------------------------------
   hls_sequencer #(.DWELL_DIV(4)) DUT (.CLK_SYS_I(clk), .RESET_N_I(rst_n), .AWADDR_I(awa), .AWVALID_I(awv),
      .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr_rdy), .BRESP_O(br),
      .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv), .ARREADY_O(arr), .RDATA_O(rdt),
      .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rry), .LIMIT_UP_I(lup), .LIMIT_LO_I(llo), .DOG_I(dg),
      .ZERO_PULSE_I(zp), .ZERO_PASS_FLAG_I(1'h0), .TORQUE_LIM_I(tq), .STOPPED_I(stp), .SERVO_ON_I(1'h1),
      .MOTION_O(mo), .HOME_LATCH_O(), .IRQ_O(irq));
   hls_axis_model AX (.clk_i(clk), .motion_i(mo), .stopped_o(stp));
   initial forever #10 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      n_tests++;
      if (got !== ex)
      begin
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
         err_total++;
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Write: both channels offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      bry <= 1'h1;
      do
      begin
         @(posedge clk);
         if (awr) awv <= 1'h0;
         if (wr_rdy) wv <= 1'h0;
      end while (awv | wv | !bv);
      bry <= 1'h0;
      chk("bresp", 32'(er), 32'(br));
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er);
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      do
      begin
         @(posedge clk);
         if (arr) arv <= 1'h0;
      end while (!rv);
      v = rdt;
      rry <= 1'h0;
      chk("rresp", 32'(er), 32'(rr));
   endtask
   task automatic t_regs;
      rd(ADDR_CTRL, 2'h0); chk("ctrl", 32'h0, v);
      rd(ADDR_DWELL, 2'h0); chk("dwell", 32'h0, v);
      wr(ADDR_DWELL, 32'd6000, 2'h0);
      rd(ADDR_DWELL, 2'h0); chk("dwell", 32'd5000, v);
      wr(ADDR_DWELL, 32'h2, 2'h0);
      wr(8'h20, 32'h1, 2'h2);
      rd(8'h20, 2'h2);
      wr(ADDR_IRQ_MK, 32'h7, 2'h0);
   endtask
   // Stopper with retry bit set and no zero pass: creeps, then refuses a repeat
   task automatic t_stop;
      wr(ADDR_CTRL, 32'h29, 2'h0); cyc(2); chk("motion", 32'h5, 32'(mo));
      tq <= 1'h1; cyc(3); tq <= 1'h0;
      rd(ADDR_STATUS, 2'h0); chk("status", 32'h1, v & 32'hd); chk("irq", 32'h1, 32'(irq));
      wr(ADDR_IRQ_ST, 32'h7, 2'h0); chk("irq", 32'h0, 32'(irq));
      wr(ADDR_CTRL, 32'h09, 2'h0); cyc(2); chk("motion", 32'h0, 32'(mo));
      rd(ADDR_ERR, 2'h0); chk("err", 32'd115, v);
   endtask
   task automatic t_lim;
      wr(ADDR_CTRL, 32'h0b, 2'h0); cyc(2);
      rd(ADDR_ERR, 2'h0); chk("err", 32'd142, v);
      wr(ADDR_CTRL, 32'h6b, 2'h0); cyc(2); chk("motion", 32'h4, 32'(mo));
      zp <= 1'h1; @(posedge clk); zp <= 1'h0; lup <= 1'h0; cyc(2); chk("motion", 32'h0, 32'(mo));
      cyc(8); chk("motion", 32'h7, 32'(mo));
      zp <= 1'h1; @(posedge clk); zp <= 1'h0; lup <= 1'h1; cyc(2);
      rd(ADDR_STATUS, 2'h0); chk("status", 32'h9, v & 32'hd);
      wr(ADDR_CTRL, 32'h4b, 2'h0); cyc(2); llo <= 1'h0; cyc(2); chk("motion", 32'h0, 32'(mo));
      cyc(6); llo <= 1'h1; rd(ADDR_ERR, 2'h0); chk("err", 32'd1101, v);
      wr(ADDR_CTRL, 32'h4b, 2'h0); cyc(2); lup <= 1'h0; cyc(10);
      rd(ADDR_ERR, 2'h0); chk("err", 32'd120, v);
      wr(ADDR_CTRL, 32'h4b, 2'h0); cyc(2); chk("motion", 32'h7, 32'(mo));
   endtask
   // Dog method with retry: limit turns it back through the dog, no major error
   task automatic t_retry;
      zp <= 1'h1; @(posedge clk); zp <= 1'h0; lup <= 1'h1;
      wr(ADDR_CTRL, 32'h21, 2'h0); cyc(2); chk("motion", 32'h4, 32'(mo));
      lup <= 1'h0; cyc(8); chk("motion", 32'h0, 32'(mo));
      cyc(8); chk("motion", 32'h6, 32'(mo));
      dg <= 1'h1; lup <= 1'h1; cyc(2); dg <= 1'h0; cyc(4); chk("motion", 32'h0, 32'(mo));
      cyc(12); chk("motion", 32'h4, 32'(mo));
      rd(ADDR_ERR, 2'h0); chk("err", 32'd120, v);
   endtask
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // A hung handshake ends the run here
   initial
   begin
      cyc(20000);
      err_total++;
      test_done();
   end
   initial
   begin
      cyc(16);
      rst_n <= 1'h1;
      t_regs();
      t_stop();
      t_lim();
      t_retry();
      test_done();
   end
endmodule
